// ==== shared/wpd_consts.vh ====
// Purpose: constants for the wake packet detect block
// Assumes: byte offsets on a 32-bit AHB-Lite register bus
// Notes: included by rtl/wpd_top.v and rtl/wpd_crc16.v
//
// What this block does
// RL1 - each filter holds an 8-bit offset of its first checked frame byte
// RL2 - software keeps every filter offset at 12 or more
// RL3 - each filter holds a 16-bit expected CRC; equal CRC flags wake frame
// RL4 - pattern enable enters detect mode, blocks normal receive, scans data
// RL5 - a detected pattern packet sets the pattern received flag
// RL6 - pattern detection is reported on the interrupt or the power event output
// RL7 - clearing pattern enable leaves detect mode and resumes normal receive
// RL8 - detect mode examines frames to own unicast or broadcast address
// RL9 - multicast frames are also accepted when the 16 copies are found
// RL10 - after the address fields, search sync then 16 address copies anywhere
// RL11 - pattern detection works only in full power and first low power
// RL12 - in full power, pattern detection needs the pattern enable bit
// RL13 - first low power enables pattern and wake frame detection regardless
// RL14 - 31-bit byte mask: bit j includes byte offset plus j in the CRC
// RL15 - command bit 3 selects multicast frames when set, unicast when clear
// RL16 - command bit 0 enables the filter; disabled filters never match
// RL17 - sync stream is six 0xFF bytes directly before the first copy
// RL18 - pattern received flag stays set until software clears it
`ifndef WPD_CONSTS_VH
`define WPD_CONSTS_VH
// ****************************
// register byte offsets
// ****************************
`define WPD_OFS_CTRL 8'h00
`define WPD_OFS_STS 8'h04
`define WPD_OFS_MASK 8'h08
`define WPD_OFS_ADDR_LO 8'h0C
`define WPD_OFS_ADDR_HI 8'h10
`define WPD_OFS_FCMD 8'h14
`define WPD_OFS_FOFS 8'h18
`define WPD_OFS_FCRC01 8'h1C
`define WPD_OFS_FCRC23 8'h20
`define WPD_OFS_FMASK0 8'h24
// ****************************
// fields
// ****************************
`define WPD_CTRL_WFEN 0
`define WPD_CTRL_PDEN 1
`define WPD_CTRL_EVSEL 2
`define WPD_STS_PAT 0
`define WPD_STS_WF 1
`define WPD_FCMD_EN 0
`define WPD_FCMD_MC 3
`define WPD_FCMD_WMASK 32'h0909_0909
// ****************************
// power states
// ****************************
`define WPD_PS_FULL 2'b00
`define WPD_PS_LOW1 2'b01
// ****************************
// frame and pattern figures
// ****************************
`define WPD_ADDR_BYTES 3'd6
`define WPD_HDR_BYTES 11'd12
`define WPD_SYNC_FF 3'd6
`define WPD_REPS 5'd16
`define WPD_MASK_BITS 11'd31
`define WPD_CRC_INIT 16'hFFFF
`define WPD_CRC_POLY 16'h8005
`endif

// ==== rtl/wpd_crc16.v ====
// Purpose: one byte step of the filter CRC-16
// Assumes: data bits enter least significant first
// Notes: purely combinational
`timescale 1ns/1ps
`default_nettype none
`include "wpd_consts.vh"
module wpd_crc16 #(
  parameter [15:0] POLY = `WPD_CRC_POLY
) (
  // state in
  input wire [15:0] CRC_IN,
  input wire [7:0] DATA,
  // state out
  output reg [15:0] CRC_OUT
);
  integer k;
  reg fb;
  always @*
  begin
    CRC_OUT = CRC_IN;
    fb = 1'b0;
    for (k = 0; k < 8; k = k + 1)
    begin
      fb = CRC_OUT[15] ^ DATA[k];
      CRC_OUT = {CRC_OUT[14:0], 1'b0} ^ (fb ? POLY : 16'h0000);
    end
  end
endmodule
`default_nettype wire

// ==== rtl/wpd_top.v ====
// Purpose: wake frame filters and pattern packet detection
// Assumes: byte stream from the receive datapath on REF_CLK
// Notes: registers over AHB-Lite, reads take one wait state
//
// Implementation choices: the AHB-Lite interface to the registers and the address map.
`timescale 1ns/1ps
`default_nettype none
`include "wpd_consts.vh"
module wpd_top #(
  parameter NUM_FILT = 4,
  parameter AW = 8
) (
  // clock and reset
  input wire REF_CLK,
  input wire RESETN,
  // ahb-lite slave
  input wire HSEL,
  input wire [AW-1:0] HADDR,
  input wire [1:0] HTRANS,
  input wire HWRITE,
  input wire [31:0] HWDATA,
  input wire HREADY,
  output reg [31:0] HRDATA,
  output reg HREADYOUT,
  output reg HRESP,
  // receive byte stream
  input wire RX_VALID,
  input wire [7:0] RX_DATA,
  input wire RX_LAST,
  // power state
  input wire [1:0] POWER_STATE,
  // outputs
  output reg RX_SUPPRESS,
  output reg IRQ,
  output reg POWER_EVENT_OUT
);
  // ****************************
  // registers
  // ****************************
  reg [2:0] ctrl_reg;
  reg [1:0] sts_reg;
  reg [1:0] sts_next;
  reg [1:0] mask_reg;
  reg [31:0] addr_lo_reg;
  reg [15:0] addr_hi_reg;
  reg [31:0] fcmd_reg;
  reg [31:0] fofs_reg;
  reg [63:0] fcrc_reg;
  reg [30:0] fmask_reg [0:NUM_FILT-1];
  reg wr_pend_reg;
  reg rd_pend_reg;
  reg [7:0] acc_addr_reg;
  reg [31:0] rd_data;
  integer i;
  integer j;

  wire [7:0] addr8 = {HADDR[7:2], 2'b00};
  wire addr_ph = HSEL & HTRANS[1] & HREADY;
  wire wr_now = wr_pend_reg;
  wire [31:0] clr_word = (wr_now && acc_addr_reg == `WPD_OFS_STS) ? HWDATA : 32'h0000_0000;

  function [7:0] addr_byte;
    input [2:0] idx;
    input [47:0] a;
    begin
      case (idx)
        3'd0: addr_byte = a[7:0];
        3'd1: addr_byte = a[15:8];
        3'd2: addr_byte = a[23:16];
        3'd3: addr_byte = a[31:24];
        3'd4: addr_byte = a[39:32];
        default: addr_byte = a[47:40];
      endcase
    end
  endfunction

  wire [47:0] node_addr = {addr_hi_reg, addr_lo_reg};

  // ****************************
  // effective enables
  // ****************************
  wire ps_full = POWER_STATE == `WPD_PS_FULL;
  wire ps_low1 = POWER_STATE == `WPD_PS_LOW1;
  wire pat_act = (ps_full & ctrl_reg[`WPD_CTRL_PDEN]) | ps_low1; // RL11 RL12 RL13
  wire frm_act = (ps_full & ctrl_reg[`WPD_CTRL_WFEN]) | ps_low1; // RL13

  // ****************************
  // frame position and destination
  // ****************************
  reg [10:0] cnt_reg;
  reg uc_reg;
  reg bc_reg;
  reg mc_reg;
  reg uc_next;
  reg bc_next;
  reg mc_next;
  wire in_da = cnt_reg < {8'd0, `WPD_ADDR_BYTES};
  wire first = cnt_reg == 11'd0;

  always @*
  begin
    uc_next = uc_reg;
    bc_next = bc_reg;
    mc_next = mc_reg;
    if (RX_VALID && in_da)
    begin
      uc_next = (first | uc_reg) & (RX_DATA == addr_byte(cnt_reg[2:0], node_addr));
      bc_next = (first | bc_reg) & (RX_DATA == 8'hFF);
      if (first)
        mc_next = RX_DATA[0];
    end
  end

  // ****************************
  // pattern search
  // ****************************
  reg [2:0] ff_reg;
  reg [2:0] bi_reg;
  reg [4:0] rep_reg;
  reg run_reg;
  reg found_reg;
  reg [2:0] ff_next;
  reg [2:0] bi_next;
  reg [4:0] rep_next;
  reg run_next;
  reg found_next;
  wire is_ff = RX_DATA == 8'hFF;
  wire [2:0] ff_inc = (ff_reg == 3'd7) ? ff_reg : ff_reg + 3'd1;

  always @*
  begin
    ff_next = ff_reg;
    bi_next = bi_reg;
    rep_next = rep_reg;
    run_next = run_reg;
    found_next = found_reg;
    if (RX_VALID && cnt_reg >= `WPD_HDR_BYTES) // RL10
    begin
      if (run_reg)
      begin
        if (RX_DATA == addr_byte(bi_reg, node_addr))
        begin
          if (bi_reg == `WPD_ADDR_BYTES - 3'd1)
          begin
            bi_next = 3'd0;
            rep_next = rep_reg + 5'd1;
            if (rep_reg == `WPD_REPS - 5'd1)
            begin
              found_next = 1'b1; // RL10
              run_next = 1'b0;
            end
          end
          else
            bi_next = bi_reg + 3'd1;
          ff_next = 3'd0;
        end
        else
        begin
          run_next = 1'b0;
          bi_next = 3'd0;
          rep_next = 5'd0;
          ff_next = is_ff ? 3'd1 : 3'd0;
        end
      end
      else
      begin
        if (ff_reg >= `WPD_SYNC_FF && RX_DATA == addr_byte(3'd0, node_addr)) // RL17
        begin
          run_next = 1'b1;
          bi_next = 3'd1;
          rep_next = 5'd0;
        end
        ff_next = is_ff ? ff_inc : 3'd0; // RL17
      end
    end
  end

  // ****************************
  // wake frame filters
  // ****************************
  wire [NUM_FILT-1:0] filt_hit;
  genvar g;
  generate
    for (g = 0; g < NUM_FILT; g = g + 1)
    begin : filt
      reg [15:0] crc_reg;
      wire [15:0] crc_upd;
      wire [7:0] ofs = fofs_reg[8*g+7:8*g]; // RL1
      wire [10:0] rel = cnt_reg - {3'd0, ofs};
      wire in_win = (cnt_reg >= {3'd0, ofs}) && (rel < `WPD_MASK_BITS)
        && fmask_reg[g][rel[4:0]]; // RL14
      wire [15:0] crc_next = (RX_VALID && in_win) ? crc_upd : crc_reg;
      wire type_ok = fcmd_reg[8*g+`WPD_FCMD_MC] ? mc_next : ~mc_next; // RL15
      wpd_crc16 u_crc (
        .CRC_IN(crc_reg),
        .DATA(RX_DATA),
        .CRC_OUT(crc_upd)
      );
      assign filt_hit[g] = fcmd_reg[8*g+`WPD_FCMD_EN] & type_ok // RL16
        & (crc_next == fcrc_reg[16*g+15:16*g]); // RL3
      always @(posedge REF_CLK)
      begin
        if (!RESETN || (RX_VALID && RX_LAST))
          crc_reg <= `WPD_CRC_INIT;
        else
          crc_reg <= crc_next; // RL3
      end
    end
  endgenerate

  // ****************************
  // events
  // ****************************
  wire frame_end = RX_VALID & RX_LAST;
  wire dest_ok = uc_next | bc_next; // RL8
  wire pat_hit = frame_end & pat_act & found_next & (dest_ok | mc_next); // RL5 RL9
  wire wf_hit = frame_end & frm_act & (|filt_hit);

  always @*
  begin
    sts_next = sts_reg & ~clr_word[1:0];
    if (pat_hit)
      sts_next[`WPD_STS_PAT] = 1'b1; // RL5 RL18
    if (wf_hit)
      sts_next[`WPD_STS_WF] = 1'b1;
  end

  // ****************************
  // receive state registers
  // ****************************
  always @(posedge REF_CLK)
  begin
    if (!RESETN || frame_end)
    begin
      cnt_reg <= 11'd0;
      uc_reg <= 1'b0;
      bc_reg <= 1'b0;
      mc_reg <= 1'b0;
      ff_reg <= 3'd0;
      bi_reg <= 3'd0;
      rep_reg <= 5'd0;
      run_reg <= 1'b0;
      found_reg <= 1'b0;
    end
    else
    begin
      if (RX_VALID && cnt_reg != 11'h7FF)
        cnt_reg <= cnt_reg + 11'd1;
      uc_reg <= uc_next;
      bc_reg <= bc_next;
      mc_reg <= mc_next;
      ff_reg <= ff_next;
      bi_reg <= bi_next;
      rep_reg <= rep_next;
      run_reg <= run_next;
      found_reg <= found_next;
    end
  end

  // ****************************
  // register read mux
  // ****************************
  always @*
  begin
    rd_data = 32'h0000_0000;
    case (acc_addr_reg)
      `WPD_OFS_CTRL: rd_data = {29'd0, ctrl_reg};
      `WPD_OFS_STS: rd_data = {30'd0, sts_reg};
      `WPD_OFS_MASK: rd_data = {30'd0, mask_reg};
      `WPD_OFS_ADDR_LO: rd_data = addr_lo_reg;
      `WPD_OFS_ADDR_HI: rd_data = {16'd0, addr_hi_reg};
      `WPD_OFS_FCMD: rd_data = fcmd_reg;
      `WPD_OFS_FOFS: rd_data = fofs_reg;
      `WPD_OFS_FCRC01: rd_data = fcrc_reg[31:0];
      `WPD_OFS_FCRC23: rd_data = fcrc_reg[63:32];
      default:
      begin
        for (j = 0; j < NUM_FILT; j = j + 1)
          if (acc_addr_reg == `WPD_OFS_FMASK0 + 8'd4 * j[7:0])
            rd_data = {1'b0, fmask_reg[j]};
      end
    endcase
  end

  // ****************************
  // bus slave and register writes
  // ****************************
  always @(posedge REF_CLK)
  begin
    if (!RESETN)
    begin
      wr_pend_reg <= 1'b0;
      rd_pend_reg <= 1'b0;
      acc_addr_reg <= 8'h00;
      HREADYOUT <= 1'b1;
      HRESP <= 1'b0;
      HRDATA <= 32'h0000_0000;
      ctrl_reg <= 3'd0;
      sts_reg <= 2'd0;
      mask_reg <= 2'd0;
      addr_lo_reg <= 32'h0000_0000;
      addr_hi_reg <= 16'h0000;
      fcmd_reg <= 32'h0000_0000;
      fofs_reg <= 32'h0000_0000;
      fcrc_reg <= 64'h0000_0000_0000_0000;
      for (i = 0; i < NUM_FILT; i = i + 1)
        fmask_reg[i] <= 31'd0;
      RX_SUPPRESS <= 1'b0;
      IRQ <= 1'b0;
      POWER_EVENT_OUT <= 1'b0;
    end
    else
    begin
      HRESP <= 1'b0;
      sts_reg <= sts_next; // RL18
      RX_SUPPRESS <= pat_act; // RL4 RL7
      IRQ <= ~ctrl_reg[`WPD_CTRL_EVSEL] & (|(sts_reg & mask_reg)); // RL6
      POWER_EVENT_OUT <= ctrl_reg[`WPD_CTRL_EVSEL] & (|(sts_reg & mask_reg)); // RL6
      wr_pend_reg <= 1'b0;
      if (rd_pend_reg)
      begin
        HRDATA <= rd_data;
        HREADYOUT <= 1'b1;
        rd_pend_reg <= 1'b0;
      end
      else if (addr_ph)
      begin
        acc_addr_reg <= addr8;
        wr_pend_reg <= HWRITE;
        rd_pend_reg <= ~HWRITE;
        HREADYOUT <= HWRITE;
      end
      if (wr_now)
      begin
        case (acc_addr_reg)
          `WPD_OFS_CTRL: ctrl_reg <= HWDATA[2:0]; // RL4 RL7
          `WPD_OFS_MASK: mask_reg <= HWDATA[1:0];
          `WPD_OFS_ADDR_LO: addr_lo_reg <= HWDATA;
          `WPD_OFS_ADDR_HI: addr_hi_reg <= HWDATA[15:0];
          `WPD_OFS_FCMD: fcmd_reg <= HWDATA & `WPD_FCMD_WMASK;
          `WPD_OFS_FOFS: fofs_reg <= HWDATA; // RL1 RL2
          `WPD_OFS_FCRC01: fcrc_reg[31:0] <= HWDATA;
          `WPD_OFS_FCRC23: fcrc_reg[63:32] <= HWDATA;
          default:
          begin
            for (i = 0; i < NUM_FILT; i = i + 1)
              if (acc_addr_reg == `WPD_OFS_FMASK0 + 8'd4 * i[7:0])
                fmask_reg[i] <= HWDATA[30:0]; // RL14
          end
        endcase
      end
    end
  end
endmodule
`default_nettype wire

// ==== verification/wpd_rx_model.sv ====
// Purpose: receive datapath model feeding bytes
// Assumes: bench fills q with {last, byte}
// Notes: slow mode leaves gaps between bytes
`timescale 1ns/1ps
`default_nettype none
module wpd_rx_model (
  // clock and pace
  input wire logic clk,
  input wire logic slow,
  // byte stream
  output logic vld = 1'b0,
  output logic [7:0] dat = 8'h00,
  output logic lst = 1'b0
);
  logic [8:0] q[$];
  logic gap = 1'b0;
  // ****
  // byte pump
  // ****
  always @(posedge clk)
  begin
    gap <= slow & ~gap;
    if (q.size() > 0 && !gap)
    begin
      vld <= 1'b1;
      {lst, dat} <= q.pop_front();
    end
    else
    begin
      vld <= 1'b0;
      lst <= 1'b0;
      dat <= ~dat;
    end
  end
endmodule
`default_nettype wire

// ==== verification/wpd_top_asserts.sv ====
// Purpose: port checks for wpd_top
// Assumes: HREADY tied to HREADYOUT
// Notes: bound below the module
`timescale 1ns/1ps
`default_nettype none
module wpd_top_asserts #(
  parameter NUM_FILT = 4,
  parameter AW = 8
) (
  // clock and reset
  input wire logic REF_CLK,
  input wire logic RESETN,
  // bus
  input wire logic HSEL,
  input wire logic [1:0] HTRANS,
  input wire logic HWRITE,
  input wire logic HREADY,
  input wire logic HREADYOUT,
  input wire logic HRESP,
  // receive and power
  input wire logic RX_VALID,
  input wire logic RX_LAST,
  input wire logic [1:0] POWER_STATE,
  // outputs
  input wire logic RX_SUPPRESS,
  input wire logic IRQ,
  input wire logic POWER_EVENT_OUT
);
  // ****
  // checks
  // ****
  default clocking cb @(posedge REF_CLK); endclocking
  default disable iff (!RESETN);
  wire logic tk = HSEL & HTRANS[1] & HREADY;
  wire logic wr = tk & HWRITE;
  wire logic ev = wr | (RX_VALID & RX_LAST);
  a_resp_okay: assert property (!HRESP) else $error("hresp set");
  a_read_wait: assert property (tk && !HWRITE |=> !HREADYOUT ##1 HREADYOUT)
    else $error("read wait");
  a_write_nowait: assert property (wr |=> HREADYOUT) else $error("write wait");
  a_one_output: assert property (!(IRQ && POWER_EVENT_OUT))
    else $error("irq and power event");
  a_low_detect: assert property (POWER_STATE == 2'b01 |=> RX_SUPPRESS)
    else $error("low power idle");
  a_off_detect: assert property (POWER_STATE[1] |=> !RX_SUPPRESS)
    else $error("detect in off state");
  a_rise_cause: assert property ($rose(IRQ) || $rose(POWER_EVENT_OUT)
    |-> $past(ev, 2) || $past(ev, 3) || $past(ev, 4)) else $error("rise no cause");
  a_flag_sticky: assert property ($fell(IRQ) || $fell(POWER_EVENT_OUT)
    |-> $past(wr, 2) || $past(wr, 3) || $past(wr, 4)) else $error("fall no write");
  c_read: cover property (tk && !HWRITE);
  c_irq: cover property ($rose(IRQ));
  c_pwr_ev: cover property ($rose(POWER_EVENT_OUT));
endmodule
bind wpd_top wpd_top_asserts #(.NUM_FILT(NUM_FILT), .AW(AW)) i_chk (
  .REF_CLK(REF_CLK), .RESETN(RESETN), .HSEL(HSEL), .HTRANS(HTRANS), .HWRITE(HWRITE),
  .HREADY(HREADY), .HREADYOUT(HREADYOUT), .HRESP(HRESP), .RX_VALID(RX_VALID),
  .RX_LAST(RX_LAST), .POWER_STATE(POWER_STATE), .RX_SUPPRESS(RX_SUPPRESS),
  .IRQ(IRQ), .POWER_EVENT_OUT(POWER_EVENT_OUT));
`default_nettype wire

// ==== verification/tb_wpd_top.sv ====
// Purpose: self-checking bench for wpd_top
// Assumes: one ahb master, one receive model
// Notes: expected status from a bench model
`timescale 1ns/1ps
`default_nettype none
module tb_wpd_top;
  logic ref_clk = 1'b0, resetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, slow = 1'b0;
  logic [7:0] haddr = 8'h00;
  logic [1:0] htrans = 2'h0, ps = 2'h0, es = 2'h0;
  logic [31:0] hwdata = 32'h0000_0000, rd, w;
  logic [15:0] fcrc;
  wire logic [31:0] hrdata;
  wire logic hrdy, hresp, rxv, rxl, sup, irq, pwr_ev;
  logic [1:0] mk = 2'h3;
  wire logic [7:0] rxd;
  logic [7:0] na[6];
  logic [7:0] fb[$];
  logic [31:0] msk[14] = '{32'h0000_0007, 32'h0000_0000, 32'h0000_0003, 32'hffff_ffff,
    32'h0000_ffff, 32'h0909_0909, 32'hffff_ffff, 32'hffff_ffff, 32'hffff_ffff,
    32'h7fff_ffff, 32'h7fff_ffff, 32'h7fff_ffff, 32'h7fff_ffff, 32'h0000_0000};
  integer fail_count = 0, n_checks = 0, k;
  always #20 ref_clk = ~ref_clk;
  wpd_top i_dut (.REF_CLK(ref_clk), .RESETN(resetn), .HSEL(hsel), .HADDR(haddr),
    .HTRANS(htrans), .HWRITE(hwrite), .HWDATA(hwdata), .HREADY(hrdy), .HRDATA(hrdata),
    .HREADYOUT(hrdy), .HRESP(hresp), .RX_VALID(rxv), .RX_DATA(rxd), .RX_LAST(rxl),
    .POWER_STATE(ps), .RX_SUPPRESS(sup), .IRQ(irq), .POWER_EVENT_OUT(pwr_ev));
  wpd_rx_model i_rx (.clk(ref_clk), .slow(slow), .vld(rxv), .dat(rxd), .lst(rxl));
  // ****
  // tasks
  // ****
  task test_done;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] s);
    n_checks++;
    if (s !== e)
    begin
      fail_count++;
      $display("BAD %s expected %h seen %h", n, e, s);
    end
  endtask
  task wt;
    k = 0;
    @(posedge ref_clk);
    while (hrdy !== 1'b1)
    begin
      if (++k > 20)
      begin
        chk("bus timeout", 0, 1);
        test_done;
      end
      @(posedge ref_clk);
    end
  endtask
  task bus(input logic wn, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    {hsel, htrans, hwrite, haddr} <= {1'b1, 2'h2, wn, a};
    wt;
    {hsel, htrans} <= 3'h0;
    if (wn)
      hwdata <= d;
    wt;
    rd = hrdata;
  endtask
  function automatic logic [15:0] crc16(input logic [15:0] c, input logic [7:0] d);
    for (int i = 0; i < 8; i++)
      c = {c[14:0], 1'b0} ^ (c[15] ^ d[i] ? 16'h8005 : 16'h0000);
    return c;
  endfunction
  task run(input logic [1:0] p_s, input logic [2:0] ct, input int da, input int nff,
    input logic [3:0] cm, input logic clr);
    logic [15:0] c;
    logic f, p;
    ps <= p_s;
    slow <= 1'($urandom % 2);
    bus(1, 8'h00, 32'(ct));
    bus(1, 8'h14, 32'(cm));
    fb = {};
    for (int i = 0; i < 12; i++)
      fb.push_back(i > 5 ? 8'h02 : da == 1 ? 8'hff : da == 3 && i == 0 ? 8'h01 : na[i] ^ 8'(da));
    if (nff > 0)
      repeat ($urandom % 4) fb.push_back(8'h5a);
    repeat (nff) fb.push_back(8'hff);
    repeat (16) foreach (na[i]) fb.push_back(na[i]);
    fb.push_back(8'h00);
    c = 16'hffff;
    for (int i = 12; i < 16; i++)
      c = crc16(c, fb[i]);
    f = (p_s == 0 && ct[0] || p_s == 1) && cm[0] && cm[3] == fb[0][0] && c == fcrc;
    p = (p_s == 0 && ct[1] || p_s == 1) && da != 2 && nff >= 6;
    es = es | {f, p};
    foreach (fb[i])
      i_rx.q.push_back({i == fb.size() - 1, fb[i]});
    k = 0;
    while (i_rx.q.size() > 0 && k < 900)
    begin
      @(posedge ref_clk);
      k++;
    end
    if (k == 900)
    begin
      chk("rx drain", 0, 1);
      test_done;
    end
    repeat (4) @(posedge ref_clk);
    bus(0, 8'h04, 0);
    chk("status", 32'(es), rd);
    chk("irq", 32'((es & mk) != 0 && !ct[2]), 32'(irq));
    chk("power event", 32'((es & mk) != 0 && ct[2]), 32'(pwr_ev));
    chk("suppress", 32'(p_s == 1 || p_s == 0 && ct[1]), 32'(sup));
    if (clr)
    begin
      bus(1, 8'h04, 32'h0000_0003);
      es = 0;
    end
  endtask
  // ****
  // sequence
  // ****
  initial
  begin
    void'($urandom(32'h0331));
    repeat (8) @(posedge ref_clk);
    resetn <= 1'b1;
    for (int i = 0; i < 14; i++)
    begin
      bus(0, i == 13 ? 8'h40 : 8'(4 * i), 0);
      chk("reset value", 0, rd);
      w = $urandom;
      bus(1, i == 13 ? 8'h40 : 8'(4 * i), w);
      bus(0, i == 13 ? 8'h40 : 8'(4 * i), 0);
      chk("readback", w & msk[i], rd);
    end
    foreach (na[i])
      na[i] = 8'($urandom) & (i == 0 ? 8'h7e : 8'h7f);
    fcrc = 16'hffff;
    for (int i = 0; i < 4; i++)
      fcrc = crc16(fcrc, na[i]);
    bus(1, 8'h08, 32'h0000_0003);
    bus(1, 8'h0c, {na[3], na[2], na[1], na[0]});
    bus(1, 8'h10, {16'h0000, na[5], na[4]});
    bus(1, 8'h18, 32'h0c0c_0c0c);
    bus(1, 8'h1c, 32'(fcrc));
    bus(1, 8'h24, 32'h0000_000f);
    bus(1, 8'h04, 32'h0000_0003);
    run(0, 3'h2, 0, 6, 4'h0, 0);
    run(0, 3'h2, 2, 7, 4'h0, 1);
    run(0, 3'h6, 1, 7, 4'h0, 1);
    run(0, 3'h2, 3, 6, 4'h0, 1);
    run(0, 3'h2, 0, 5, 4'h0, 1);
    run(0, 3'h0, 0, 6, 4'h0, 1);
    run(1, 3'h0, 0, 6, 4'h0, 1);
    run(2, 3'h2, 0, 6, 4'h0, 1);
    run(3, 3'h3, 0, 6, 4'h1, 1);
    run(0, 3'h1, 0, 0, 4'h1, 1);
    run(0, 3'h1, 0, 0, 4'h9, 1);
    run(0, 3'h1, 3, 0, 4'h9, 1);
    run(0, 3'h1, 0, 0, 4'h0, 1);
    bus(1, 8'h08, 32'h0000_0001);
    mk = 2'h1;
    run(1, 3'h0, 0, 0, 4'h1, 1);
    test_done;
  end
endmodule
`default_nettype wire
